/* File: rtl/nsx_defines.vh */
// Opcode patterns, field positions and reset values for the execution unit
`ifndef NSX_DEFINES_VH
`define NSX_DEFINES_VH

`define NSX_INSTR_W 14
`define NSX_DATA_W 8
`define NSX_FADDR_W 7

// Opcode fields
`define NSX_SWAP_OPC_HI 13
`define NSX_SWAP_OPC_LO 8
`define NSX_SWAP_OPC 6'h0e
`define NSX_DEST_BIT 7
`define NSX_XORI_OPC_HI 13
`define NSX_XORI_OPC_LO 8
`define NSX_XORI_OPC 6'h3a
`define NSX_DIRL_OPC_HI 13
`define NSX_DIRL_OPC_LO 3
`define NSX_DIRL_OPC 11'h00c
`define NSX_DIRL_SEL_HI 2
`define NSX_DIRL_SEL_LO 0
`define NSX_DIRL_SEL_MIN 3'h5
`define NSX_DIRL_SEL_MAX 3'h7

// Destination select values
`define NSX_DEST_ACCUM 1'h0
`define NSX_DEST_FILE 1'h1

// File addresses of the three direction registers
`define NSX_DIR5_FADDR 7'h65
`define NSX_DIR6_FADDR 7'h66
`define NSX_DIR7_FADDR 7'h67

// Direction registers come out of reset with every pin an input
`define NSX_DIR_RESET 8'hff

`endif

/* File: rtl/nsx_dir_reg.v */
// One port direction register with a file-bus write and an instruction write
module nsx_dir_reg
#(
	parameter WIDTH = 8,
	parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
)
(
	input wire clock,
	input wire rst_b,
	input wire busWe,
	input wire [WIDTH-1:0] busData,
	input wire opWe,
	input wire [WIDTH-1:0] opData,
	output reg [WIDTH-1:0] value_r
);

	reg [WIDTH-1:0] value_nxt;

	// The executing instruction wins over a file-bus write in the same cycle
	always @*
	begin
		value_nxt = value_r;
		if (opWe)
			value_nxt = opData;
		else if (busWe)
			value_nxt = busData;
	end

	always @(posedge clock)
	begin
		if (!rst_b)
			value_r <= RESET_VAL;
		else
			value_r <= value_nxt;
	end

endmodule // nsx_dir_reg

/* File: rtl/nsx_exec_unit.v */
// Execution of nibble swap, XOR with immediate and direction load
// Notes on behaviour
// - Swap places file bits 3..0 in result 7..4 and bits 7..4 in 3..0.
// - Swap result goes to accumulator when dest bit is 0, file when 1.
// - XOR-immediate combines accumulator with an 8-bit literal by bitwise XOR.
// - XOR-immediate always writes the accumulator; it has no destination bit.
// - Direction load copies accumulator to direction register 5, 6 or 7.
// - Direction load stays decoded and executed as a legacy opcode.
// - Direction registers are also read and written as plain file registers.
`include "nsx_defines.vh"

module nsx_exec_unit
#(
	parameter DATA_W = `NSX_DATA_W,
	parameter FADDR_W = `NSX_FADDR_W,
	parameter NUM_DIR = 3
)
(
	input wire clock,
	input wire rst_b,
	input wire instrValid,
	input wire [`NSX_INSTR_W-1:0] instrWord,
	input wire [DATA_W-1:0] accumIn,
	input wire [DATA_W-1:0] fileRdData,
	input wire dirBusWe,
	input wire [FADDR_W-1:0] dirBusAddr,
	input wire [DATA_W-1:0] dirBusWrData,
	output reg [DATA_W-1:0] dirBusRdData_r,
	output reg dirBusHit_r,
	output reg accumWrEn_r,
	output reg [DATA_W-1:0] accumWrData_r,
	output reg fileWrEn_r,
	output reg [FADDR_W-1:0] fileWrAddr_r,
	output reg [DATA_W-1:0] fileWrData_r,
	output reg zeroWrEn_r,
	output reg zeroVal_r,
	output reg illegalOp_r,
	output wire [NUM_DIR*DATA_W-1:0] dirRegs
);

	localparam [FADDR_W-1:0] DIR5_ADDR = `NSX_DIR5_FADDR;
	localparam [FADDR_W-1:0] DIR6_ADDR = `NSX_DIR6_FADDR;
	localparam [FADDR_W-1:0] DIR7_ADDR = `NSX_DIR7_FADDR;
	localparam [DATA_W-1:0] DIR_RESET = `NSX_DIR_RESET;

	wire isSwap;
	wire isXori;
	wire isDirLoad;
	wire destBit;
	wire [FADDR_W-1:0] fAddr;
	wire [2:0] dirSel;
	wire dirSelOk;
	wire [DATA_W-1:0] literal;
	wire [DATA_W-1:0] dirVal5;
	wire [DATA_W-1:0] dirVal6;
	wire [DATA_W-1:0] dirVal7;

	reg [DATA_W-1:0] swapSrc;
	reg swapHitsDir;
	reg [DATA_W-1:0] swapRes;
	reg [DATA_W-1:0] xorRes;
	reg [NUM_DIR-1:0] opWe;
	reg [DATA_W-1:0] opData;
	reg [NUM_DIR-1:0] busWe;
	reg [DATA_W-1:0] busRd;
	reg busHit;

	reg accumWrEn_nxt;
	reg [DATA_W-1:0] accumWrData_nxt;
	reg fileWrEn_nxt;
	reg [FADDR_W-1:0] fileWrAddr_nxt;
	reg [DATA_W-1:0] fileWrData_nxt;
	reg zeroWrEn_nxt;
	reg zeroVal_nxt;
	reg illegalOp_nxt;

	// Each opcode is matched on its full fixed field, so no word decodes twice
	assign isSwap = instrValid &&
		instrWord[`NSX_SWAP_OPC_HI:`NSX_SWAP_OPC_LO] == `NSX_SWAP_OPC;
	assign isXori = instrValid &&
		instrWord[`NSX_XORI_OPC_HI:`NSX_XORI_OPC_LO] == `NSX_XORI_OPC;
	assign isDirLoad = instrValid &&
		instrWord[`NSX_DIRL_OPC_HI:`NSX_DIRL_OPC_LO] == `NSX_DIRL_OPC;
	assign destBit = instrWord[`NSX_DEST_BIT];
	assign fAddr = instrWord[FADDR_W-1:0];
	assign literal = instrWord[DATA_W-1:0];
	assign dirSel = instrWord[`NSX_DIRL_SEL_HI:`NSX_DIRL_SEL_LO];
	assign dirSelOk = dirSel >= `NSX_DIRL_SEL_MIN &&
		dirSel <= `NSX_DIRL_SEL_MAX;

	// A swap on a direction register must read the live value held here
	always @*
	begin
		swapHitsDir = 1'b1;
		if (fAddr == DIR5_ADDR)
			swapSrc = dirVal5;
		else if (fAddr == DIR6_ADDR)
			swapSrc = dirVal6;
		else if (fAddr == DIR7_ADDR)
			swapSrc = dirVal7;
		else
		begin
			swapSrc = fileRdData;
			swapHitsDir = 1'b0;
		end
	end

	always @*
	begin
		swapRes = {swapSrc[3:0], swapSrc[7:4]};
		xorRes = accumIn ^ literal;
	end

	// Direction register write enables from the instruction side
	always @*
	begin
		opWe = {NUM_DIR{1'b0}};
		opData = accumIn;
		if (isDirLoad && dirSelOk)
		begin
			opData = accumIn;
			if (dirSel == 3'h5)
				opWe[0] = 1'b1;
			else if (dirSel == 3'h6)
				opWe[1] = 1'b1;
			else
				opWe[2] = 1'b1;
		end
		else if (isSwap && destBit == `NSX_DEST_FILE && swapHitsDir)
		begin
			opData = swapRes;
			if (fAddr == DIR5_ADDR)
				opWe[0] = 1'b1;
			else if (fAddr == DIR6_ADDR)
				opWe[1] = 1'b1;
			else
				opWe[2] = 1'b1;
		end
	end

	// Plain file-register access to the direction registers
	always @*
	begin
		busWe = {NUM_DIR{1'b0}};
		busRd = {DATA_W{1'b0}};
		busHit = 1'b1;
		if (dirBusAddr == DIR5_ADDR)
		begin
			busWe[0] = dirBusWe;
			busRd = dirVal5;
		end
		else if (dirBusAddr == DIR6_ADDR)
		begin
			busWe[1] = dirBusWe;
			busRd = dirVal6;
		end
		else if (dirBusAddr == DIR7_ADDR)
		begin
			busWe[2] = dirBusWe;
			busRd = dirVal7;
		end
		else
			busHit = 1'b0;
	end

	// Write-back for the cycle; unknown words leave every output idle
	always @*
	begin
		accumWrEn_nxt = 1'b0;
		accumWrData_nxt = accumWrData_r;
		fileWrEn_nxt = 1'b0;
		fileWrAddr_nxt = fileWrAddr_r;
		fileWrData_nxt = fileWrData_r;
		zeroWrEn_nxt = 1'b0;
		zeroVal_nxt = zeroVal_r;
		illegalOp_nxt = 1'b0;
		if (isSwap)
		begin
			if (destBit == `NSX_DEST_ACCUM)
			begin
				accumWrEn_nxt = 1'b1;
				accumWrData_nxt = swapRes;
			end
			else if (!swapHitsDir)
			begin
				fileWrEn_nxt = 1'b1;
				fileWrAddr_nxt = fAddr;
				fileWrData_nxt = swapRes;
			end
		end
		else if (isXori)
		begin
			accumWrEn_nxt = 1'b1;
			accumWrData_nxt = xorRes;
			zeroWrEn_nxt = 1'b1;
			zeroVal_nxt = xorRes == {DATA_W{1'b0}};
		end
		else if (isDirLoad && !dirSelOk)
			illegalOp_nxt = 1'b1;
	end

	// Every result is registered one edge after the instruction is taken
	always @(posedge clock)
	begin
		if (!rst_b)
		begin
			accumWrEn_r <= 1'b0;
			accumWrData_r <= {DATA_W{1'b0}};
			fileWrEn_r <= 1'b0;
			fileWrAddr_r <= {FADDR_W{1'b0}};
			fileWrData_r <= {DATA_W{1'b0}};
			zeroWrEn_r <= 1'b0;
			zeroVal_r <= 1'b0;
			illegalOp_r <= 1'b0;
			dirBusRdData_r <= {DATA_W{1'b0}};
			dirBusHit_r <= 1'b0;
		end
		else
		begin
			accumWrEn_r <= accumWrEn_nxt;
			accumWrData_r <= accumWrData_nxt;
			fileWrEn_r <= fileWrEn_nxt;
			fileWrAddr_r <= fileWrAddr_nxt;
			fileWrData_r <= fileWrData_nxt;
			zeroWrEn_r <= zeroWrEn_nxt;
			zeroVal_r <= zeroVal_nxt;
			illegalOp_r <= illegalOp_nxt;
			dirBusRdData_r <= busRd;
			dirBusHit_r <= busHit;
		end
	end

	nsx_dir_reg
	#(
		.WIDTH(DATA_W),
		.RESET_VAL(DIR_RESET)
	)
	uDir5
	(
		.clock(clock),
		.rst_b(rst_b),
		.busWe(busWe[0]),
		.busData(dirBusWrData),
		.opWe(opWe[0]),
		.opData(opData),
		.value_r(dirVal5)
	);

	nsx_dir_reg
	#(
		.WIDTH(DATA_W),
		.RESET_VAL(DIR_RESET)
	)
	uDir6
	(
		.clock(clock),
		.rst_b(rst_b),
		.busWe(busWe[1]),
		.busData(dirBusWrData),
		.opWe(opWe[1]),
		.opData(opData),
		.value_r(dirVal6)
	);

	nsx_dir_reg
	#(
		.WIDTH(DATA_W),
		.RESET_VAL(DIR_RESET)
	)
	uDir7
	(
		.clock(clock),
		.rst_b(rst_b),
		.busWe(busWe[2]),
		.busData(dirBusWrData),
		.opWe(opWe[2]),
		.opData(opData),
		.value_r(dirVal7)
	);

	assign dirRegs = {dirVal7, dirVal6, dirVal5};

endmodule // nsx_exec_unit

/* File: testbench/nsx_exec_chk.sv */
// Port assertions for the execution unit
module nsx_exec_chk
(
	input logic clock,
	input logic rst_b,
	input logic instrValid,
	input logic [13:0] instrWord,
	input logic [7:0] accumIn,
	input logic [7:0] fileRdData,
	input logic dirBusWe,
	input logic [6:0] dirBusAddr,
	input logic [7:0] dirBusWrData,
	input logic accumWrEn_r,
	input logic [7:0] accumWrData_r,
	input logic fileWrEn_r,
	input logic [6:0] fileWrAddr_r,
	input logic zeroWrEn_r,
	input logic zeroVal_r,
	input logic illegalOp_r,
	input logic [23:0] dirRegs
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	wire isSwap = instrValid && instrWord[13:8] == 6'h0e;
	wire isXor = instrValid && instrWord[13:8] == 6'h3a;
	wire isDir = instrValid && instrWord[13:3] == 11'h00c;
	// Swaps on direction addresses stay internal
	wire dirF = instrWord[6:0] >= 7'h65 && instrWord[6:0] <= 7'h67;
	// A swap reads the live direction register when f names one
	wire [7:0] swapSrc = instrWord[6:0] == 7'h65 ? dirRegs[7:0] :
		instrWord[6:0] == 7'h66 ? dirRegs[15:8] :
		instrWord[6:0] == 7'h67 ? dirRegs[23:16] : fileRdData;
	sequence s_load;
		isDir && instrWord[2:0] >= 3'h5;
	endsequence
	chk_swap_accum: assert property (isSwap && !instrWord[7] |=>
		accumWrEn_r && !fileWrEn_r && accumWrData_r ==
		{$past(swapSrc[3:0]), $past(swapSrc[7:4])}) else $error("swap");
	chk_swap_dir: assert property (isSwap && instrWord[7] && dirF |=>
		!fileWrEn_r && !accumWrEn_r &&
		8'(dirRegs >> {$past(instrWord[1:0]) - 2'h1, 3'h0}) ==
		{$past(swapSrc[3:0]), $past(swapSrc[7:4])}) else $error("swap dir");
	chk_swap_file: assert property (isSwap && instrWord[7] && !dirF |=>
		fileWrEn_r && !accumWrEn_r && fileWrAddr_r == $past(instrWord[6:0]))
		else $error("swap file");
	chk_xor_data: assert property (isXor |=>
		accumWrEn_r && !fileWrEn_r &&
		accumWrData_r == ($past(accumIn) ^ $past(instrWord[7:0])))
		else $error("xor data");
	chk_xor_zero: assert property (isXor |=> zeroWrEn_r &&
		zeroVal_r == (($past(accumIn) ^ $past(instrWord[7:0])) == 8'h00))
		else $error("xor zero");
	chk_dir_load: assert property (s_load |=>
		!accumWrEn_r && !fileWrEn_r && !zeroWrEn_r &&
		8'(dirRegs >> {$past(instrWord[2:0]) - 3'h5, 3'h0}) == $past(accumIn))
		else $error("dir load");
	chk_bad_sel: assert property (isDir && instrWord[2:0] < 3'h5 &&
		!dirBusWe |=> illegalOp_r && $stable(dirRegs)) else $error("bad select");
	chk_idle_quiet: assert property (!instrValid |=> !accumWrEn_r &&
		!fileWrEn_r && !zeroWrEn_r && !illegalOp_r) else $error("idle pulse");
	chk_flag_keep: assert property (isSwap || isDir |=> !zeroWrEn_r)
		else $error("flags touched");
	chk_bus_write: assert property (dirBusWe && dirBusAddr == 7'h65 &&
		!isSwap && !isDir |=> dirRegs[7:0] == $past(dirBusWrData))
		else $error("bus write");
endmodule // nsx_exec_chk

bind nsx_exec_unit nsx_exec_chk u_chk (.*);

/* File: testbench/tb_top.sv */
// Self-checking bench for the execution unit
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, rst_b, instrValid, dirBusWe, dirBusHit_r, accumWrEn_r;
	logic fileWrEn_r, zeroWrEn_r, zeroVal_r, illegalOp_r;
	logic [13:0] instrWord, w;
	logic [7:0] accumIn, fileRdData, dirBusWrData, dirBusRdData_r, a, f, res;
	logic [7:0] accumWrData_r, fileWrData_r;
	logic [6:0] dirBusAddr, fileWrAddr_r;
	logic [23:0] dirRegs;
	logic [3:0] en;
	int n_fail, checks_done, cyc;
	// Row: word, accum, file, enables {acc,file,zero,illegal}, result
	localparam logic [41:0] ROWS [9] = '{
		{14'h0e10, 8'h00, 8'ha5, 4'h8, 8'h5a}, {14'h0e90, 8'h00, 8'h3c, 4'h4, 8'hc3},
		{14'h3aaf, 8'hb5, 8'h00, 4'ha, 8'h1a}, {14'h3a5a, 8'h5a, 8'h00, 4'ha, 8'h00},
		{14'h3a00, 8'hff, 8'h00, 4'ha, 8'hff}, {14'h0064, 8'h00, 8'h00, 4'h1, 8'h00},
		{14'h0060, 8'h00, 8'h00, 4'h1, 8'h00}, {14'h3fff, 8'h00, 8'h00, 4'h0, 8'h00},
		{14'h0e65, 8'h00, 8'h12, 4'h8, 8'hff}};
	nsx_exec_unit DUT (.*);
	initial
	begin
		clock = 0;
		forever #20 clock = ~clock;
	end
	task stop_test;
		$display("fails %0d checks %0d", n_fail, checks_done);
		if (n_fail == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// Outputs are read one cycle after the word, once the edge has landed
	task exec(input logic [13:0] iw, input logic [7:0] ia, input logic [7:0] fi);
		@(posedge clock);
		#1 instrValid = 1;
		instrWord = iw;
		accumIn = ia;
		fileRdData = fi;
		@(posedge clock);
		#1 instrValid = 0;
	endtask
	task bus(input logic we, input logic [6:0] ad);
		@(posedge clock);
		#1 dirBusWe = we;
		dirBusAddr = ad;
	endtask
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 1000)
		begin
			n_fail++;
			stop_test;
		end
	end
	initial
	begin
		{rst_b, instrValid, dirBusWe, instrWord, accumIn, fileRdData} = '0;
		dirBusAddr = 7'h00;
		dirBusWrData = 8'h3c;
		repeat (3) @(posedge clock);
		#1 rst_b = 1;
		chk(dirRegs, 24'hffffff);
		chk({accumWrEn_r, fileWrEn_r, zeroWrEn_r, illegalOp_r}, 24'h0);
		chk({dirBusHit_r, dirBusRdData_r}, 24'h0);
		foreach (ROWS[i])
		begin
			{w, a, f, en, res} = ROWS[i];
			exec(w, a, f);
			chk({accumWrEn_r, fileWrEn_r, zeroWrEn_r, illegalOp_r}, en);
			if (en[3]) chk(accumWrData_r, res);
			if (en[2]) chk({fileWrAddr_r, fileWrData_r}, {w[6:0], res});
			if (en[1]) chk(zeroVal_r, res == 8'h00);
		end
		for (int s = 5; s < 8; s++)
			exec(14'(14'h0060 + s), 8'(8'h11 * s), 8'h00);
		chk(dirRegs, 24'h776655);
		bus(1, 7'h65);
		bus(0, 7'h66);
		chk({dirBusHit_r, dirBusRdData_r, dirRegs[7:0]}, 24'h1553c);
		bus(0, 7'h10);
		chk({dirBusHit_r, dirBusRdData_r}, 24'h166);
		#40 chk({dirBusHit_r, dirBusRdData_r}, 24'h0);
		exec(14'h0ee5, 8'h00, 8'h00);
		chk({fileWrEn_r, dirRegs[7:0]}, 24'hc3);
		// A word present without instrValid must leave every pulse low
		@(posedge clock);
		#1 instrWord = 14'h3aaf;
		@(posedge clock);
		#1 chk({accumWrEn_r, zeroWrEn_r}, 24'h0);
		// Back to back: the load beats a bus write, the swap then reads it
		@(posedge clock);
		#1 {instrValid, instrWord, accumIn, dirBusWe, dirBusAddr} =
			{1'b1, 14'h0066, 8'h96, 1'b1, 7'h66};
		@(posedge clock);
		#1 instrWord = 14'h0e66;
		dirBusWe = 0;
		chk(dirRegs[15:8], 8'h96);
		@(posedge clock);
		#1 instrValid = 0;
		chk({accumWrEn_r, accumWrData_r}, 24'h169);
		// Reset in mid-run brings every register back
		rst_b = 0;
		@(posedge clock);
		#1 rst_b = 1;
		chk(dirRegs, 24'hffffff);
		chk({accumWrData_r, fileWrData_r, accumWrEn_r}, 24'h0);
		exec(14'h3aaf, 8'hb5, 8'h00);
		chk({accumWrEn_r, accumWrData_r}, 24'h11a);
		stop_test;
	end
endmodule // tb_top
